// ===== verilog/modem_line_pkg.sv
// Constants for the modem line remote control block.
// Assumes a 25 MHz system clock and a byte-addressed Avalon-MM register port.
// Behaviour
// RULE1: Host retries an unanswered command at most three extra times.
// RULE2: After four unanswered attempts the host stops commands until port reopens.
// RULE3: A denied or rejected command is not retried; host disables commands.
// RULE4: Every set-RTS or set-DTR command is answered OK, even when ignored.
// RULE5: With flow control zero, set-RTS commands drive RTS to the asked level.
// RULE6: With flow control one, set-RTS commands are dropped; RTS throttles receive.
// RULE7: Line-ready mode zero obeys set-DTR; mode one drives DTR from connection.
// RULE8: CTS and DSR changes are reported only for lines enabled in the mask.
// RULE9: Host enables both lines without flow control, only DSR with it.
// RULE10: Host rewrites the mask right after each flow-control change command.
// RULE11: With flow control on, CTS paces serial transmission toward the device.
// RULE12: Inline enable one embeds notifications in data; otherwise separate datagrams.
// RULE13: Target select zero sends notifications to the last command source port.
// RULE14: Under last-port targeting, no notification before a port is known; with inline enable one the code still sends in-band ones.
// RULE15: Notifications only while a data connection exists; commands accepted always.
// RULE16: A line change counts only after 20 ms of stable new level.
// RULE17: In-band mode, host opens a connection before sending pending commands.
// RULE18: Host sends out-of-band line commands without waiting for buffered data.
// RULE19: In-band data byte 255 is doubled by sender and collapsed by receiver.
// RULE20: Each notification carries current debounced levels of all masked lines.

package modem_line_pkg;

  // ==========================================================================
  // Timing
  localparam int unsigned CLK_HZ       = 25_000_000;
  localparam int unsigned DEBOUNCE_MS  = 20;
  localparam int unsigned DEBOUNCE_CYC = DEBOUNCE_MS * (CLK_HZ / 1000);

  // ==========================================================================
  // Register map, byte addresses
  localparam logic [3:0] CTRL_OFS   = 4'h0;
  localparam logic [3:0] STATUS_OFS = 4'h4;
  localparam logic [3:0] PORT_OFS   = 4'h8;
  localparam logic [3:0] DEST_OFS   = 4'hC;

  // Control register fields
  localparam int CTRL_FC_BIT      = 0;
  localparam int CTRL_LRM_BIT     = 1;
  localparam int CTRL_INLINE_BIT  = 2;
  localparam int CTRL_TARGET_BIT  = 3;
  localparam int CTRL_MASK_LSB    = 4;
  localparam logic [5:0] CTRL_RST = 6'h00;

  // Line indices in masks and level vectors
  localparam int LINE_CTS = 0;
  localparam int LINE_DSR = 1;

  // ==========================================================================
  // Remote commands and reply codes
  typedef enum logic [2:0] {
    CMD_NONE     = 3'b000,
    CMD_SET_RTS  = 3'b001,
    CMD_SET_DTR  = 3'b010,
    CMD_SET_FC   = 3'b011,
    CMD_SET_MASK = 3'b100
  } cmd_e;

  localparam logic [7:0] REPLY_OK     = 8'h41;
  localparam logic [7:0] REPLY_REJECT = 8'h52;
  localparam logic [7:0] ESC_BYTE     = 8'hFF;

endpackage : modem_line_pkg

// ===== verilog/line_deb_if.sv
// Carrier between the control block and its line debouncer.
// Assumes one clock shared by both ends.
`timescale 1ns/1ns
`default_nettype none

interface line_deb_if;
  logic [1:0] raw;
  logic [1:0] level;
  logic [1:0] change;

  modport ctl (output raw, input level, input change);
  modport deb (input raw, output level, output change);
endinterface : line_deb_if

`default_nettype wire

// ===== verilog/line_debounce.sv
// Debouncer for the CTS and DSR inputs.
// Assumes inputs synchronous to ref_clk; resets to both lines low.
`timescale 1ns/1ns
`default_nettype none

module line_debounce #(
  parameter int unsigned STABLE_CYC = modem_line_pkg::DEBOUNCE_CYC
) (
  // Clock and reset
  input  wire logic ref_clk,
  input  wire logic rst_b,
  // Lines
  line_deb_if.deb   lines
);

  genvar g;
  generate
    for (g = 0; g < 2; g++) begin : g_line
      logic [19:0] cnt_q;
      logic        lvl_q;
      logic        chg_q;
      wire         differs = lines.raw[g] != lvl_q;
      wire         done    = cnt_q >= 20'(STABLE_CYC - 1);

      // A new level must hold for the full stable time before it is taken.
      always_ff @(posedge ref_clk) begin
        if (!rst_b) begin
          cnt_q <= 20'h00000;
          lvl_q <= 1'b0;
          chg_q <= 1'b0;
        end else begin
          chg_q <= 1'b0;
          if (!differs) begin
            cnt_q <= 20'h00000;
          end else if (done) begin // RULE16
            cnt_q <= 20'h00000;
            lvl_q <= lines.raw[g];
            chg_q <= 1'b1;
          end else begin
            cnt_q <= cnt_q + 20'h00001;
          end
        end
      end

      assign lines.level[g]  = lvl_q;
      assign lines.change[g] = chg_q;
    end
  endgenerate

endmodule : line_debounce

`default_nettype wire

// ===== verilog/modem_line_remote_control.sv
// Modem control line handling of the serial network server.
// Assumes remote commands arrive decoded with their source port, one per cycle.
// Assumes all inputs are synchronous to ref_clk.
`timescale 1ns/1ns
`default_nettype none

module modem_line_remote_control #(
  parameter int unsigned DEBOUNCE_CYC = modem_line_pkg::DEBOUNCE_CYC
) (
  // Clock and reset
  input  wire logic        ref_clk,
  input  wire logic        rst_b,
  // Avalon-MM register slave
  input  wire logic [3:0]  avs_address,
  input  wire logic        avs_read,
  input  wire logic        avs_write,
  input  wire logic [31:0] avs_writedata,
  output logic      [31:0] avs_readdata,
  output logic             avs_waitrequest,
  // Remote commands from the virtual port host
  input  wire logic        cmd_valid,
  input  wire logic [2:0]  cmd_code,
  input  wire logic        cmd_arg,
  input  wire logic [1:0]  cmd_mask,
  input  wire logic [15:0] cmd_src_port,
  output logic             rsp_valid,
  output logic [7:0]       rsp_code,
  // Network data toward the serial side
  input  wire logic        net_rx_valid,
  input  wire logic [7:0]  net_rx_byte,
  output logic             ser_out_valid,
  output logic [7:0]       ser_out_byte,
  output logic             inband_cmd_start,
  // Line-change notifications
  input  wire logic        conn_up,
  output logic             ntf_valid,
  output logic             ntf_inband,
  output logic [15:0]      ntf_port,
  output logic [1:0]       ntf_lines,
  // Serial port pins and pacing
  input  wire logic        cts_in,
  input  wire logic        dsr_in,
  input  wire logic        rx_almost_full,
  output logic             rts_out,
  output logic             dtr_out,
  output logic             ser_tx_allow
);

  // ==========================================================================
  // Debounced lines
  // Only settled levels and one-cycle change pulses leave the filter; the
  // raw pins are never used directly below.
  line_deb_if lines ();

  assign lines.raw = {dsr_in, cts_in};

  line_debounce #(
    .STABLE_CYC (DEBOUNCE_CYC)
  ) u_deb (
    .ref_clk (ref_clk),
    .rst_b   (rst_b),
    .lines   (lines)
  );

  // ==========================================================================
  // Configuration and state
  // Software and remote commands both write the control word; a command's field
  // wins over a bus write that lands in the same cycle; other bits take the bus value.
  logic [5:0]  ctrl_q;
  logic [15:0] dest_q;
  logic [15:0] last_port_q;
  logic        port_known_q;
  logic        rts_cmd_q;
  logic        dtr_cmd_q;
  logic        wait_q;
  logic [31:0] rdata_q;

  wire        flow_control_param    = ctrl_q[modem_line_pkg::CTRL_FC_BIT];
  wire        line_ready_mode       = ctrl_q[modem_line_pkg::CTRL_LRM_BIT];
  wire        inline_command_enable = ctrl_q[modem_line_pkg::CTRL_INLINE_BIT];
  wire        report_target_select  = ctrl_q[modem_line_pkg::CTRL_TARGET_BIT];
  wire [1:0]  line_report_mask      = ctrl_q[modem_line_pkg::CTRL_MASK_LSB +: 2];

  // ==========================================================================
  // Register bus decode
  wire bus_req    = avs_read | avs_write;
  wire bus_commit = avs_write & ~wait_q;
  wire sel_ctrl   = avs_address == modem_line_pkg::CTRL_OFS;
  wire sel_status = avs_address == modem_line_pkg::STATUS_OFS;
  wire sel_port   = avs_address == modem_line_pkg::PORT_OFS;
  wire sel_dest   = avs_address == modem_line_pkg::DEST_OFS;

  // Status and port are read only; unmapped offsets read zero.
  wire [31:0] status_word = {26'h0000000, conn_up, port_known_q, dtr_out, rts_out,
                             lines.level};
  wire [31:0] rd_mux = sel_ctrl   ? {26'h0000000, ctrl_q} :
                       sel_status ? status_word :
                       sel_port   ? {16'h0000, last_port_q} :
                       sel_dest   ? {16'h0000, dest_q} : 32'h00000000;

  // Waitrequest drops for one cycle after a request is seen; writes commit then.
  always_ff @(posedge ref_clk) begin
    if (!rst_b) begin
      wait_q  <= 1'b1;
      rdata_q <= 32'h00000000;
    end else begin
      wait_q <= ~(bus_req & wait_q);
      if (bus_req & wait_q) begin
        rdata_q <= avs_read ? rd_mux : 32'h00000000;
      end
    end
  end

  // ==========================================================================
  // Remote command decode
  wire cmd_rts  = cmd_valid && cmd_code == modem_line_pkg::CMD_SET_RTS;
  wire cmd_dtr  = cmd_valid && cmd_code == modem_line_pkg::CMD_SET_DTR;
  wire cmd_fc   = cmd_valid && cmd_code == modem_line_pkg::CMD_SET_FC;
  wire cmd_mask_w = cmd_valid && cmd_code == modem_line_pkg::CMD_SET_MASK;
  wire cmd_known  = cmd_rts | cmd_dtr | cmd_fc | cmd_mask_w;

  // Commands are taken whether or not a data connection exists.
  wire [5:0] ctrl_bus = bus_commit && sel_ctrl ? avs_writedata[5:0] : ctrl_q;
  wire [5:0] ctrl_fc  = cmd_fc ?
                        {ctrl_bus[5:1], cmd_arg} : ctrl_bus;
  wire [5:0] ctrl_d   = cmd_mask_w ?
                        {cmd_mask, ctrl_fc[3:0]} : ctrl_fc;

  always_ff @(posedge ref_clk) begin
    if (!rst_b) begin
      ctrl_q       <= modem_line_pkg::CTRL_RST;
      dest_q       <= 16'h0000;
      last_port_q  <= 16'h0000;
      port_known_q <= 1'b0;
    end else begin
      ctrl_q <= ctrl_d;
      if (bus_commit && sel_dest) begin
        dest_q <= avs_writedata[15:0];
      end
      if (cmd_valid) begin
        last_port_q  <= cmd_src_port; // RULE13
        port_known_q <= 1'b1; // RULE14
      end
    end
  end

  // ==========================================================================
  // Replies: set-RTS and set-DTR are always acknowledged OK.
  // The reply does not depend on whether the change was applied, so the
  // host never retries a command that was ignored on purpose.
  wire [7:0] rsp_sel = cmd_known ? modem_line_pkg::REPLY_OK // RULE4
                                 : modem_line_pkg::REPLY_REJECT;

  always_ff @(posedge ref_clk) begin
    if (!rst_b) begin
      rsp_valid <= 1'b0;
      rsp_code  <= 8'h00;
    end else begin
      rsp_valid <= cmd_valid;
      if (cmd_valid) begin
        rsp_code <= rsp_sel;
      end
    end
  end

  // ==========================================================================
  // RTS and DTR outputs
  // An ignored command leaves the stored request untouched, so the line
  // returns to the last obeyed level when the owning mode is left.
  // Under flow control the device throttles its own receive side.
  wire rts_d      = flow_control_param ? ~rx_almost_full : rts_cmd_q; // RULE6
  wire dtr_d      = line_ready_mode ? conn_up : dtr_cmd_q; // RULE7
  wire tx_allow_d = ~flow_control_param | lines.level[modem_line_pkg::LINE_CTS]; // RULE11

  always_ff @(posedge ref_clk) begin
    if (!rst_b) begin
      rts_cmd_q    <= 1'b0;
      dtr_cmd_q    <= 1'b0;
      rts_out      <= 1'b0;
      dtr_out      <= 1'b0;
      ser_tx_allow <= 1'b0;
    end else begin
      if (cmd_rts && !flow_control_param) begin
        rts_cmd_q <= cmd_arg; // RULE5
      end
      if (cmd_dtr && !line_ready_mode) begin
        dtr_cmd_q <= cmd_arg; // RULE7
      end
      rts_out      <= rts_d;
      dtr_out      <= dtr_d;
      ser_tx_allow <= tx_allow_d;
    end
  end

  // ==========================================================================
  // Line-change notifications
  wire masked_change = |(lines.change & line_report_mask); // RULE8
  wire target_ok     = report_target_select | port_known_q; // RULE14
  wire ntf_fire      = masked_change && conn_up && // RULE15
                       (inline_command_enable || target_ok);

  // Port and levels are latched with the pulse and hold until the next one.
  wire [15:0] ntf_port_d  = report_target_select ? dest_q : last_port_q; // RULE13
  wire [1:0]  ntf_lines_d = lines.level & line_report_mask; // RULE20

  always_ff @(posedge ref_clk) begin
    if (!rst_b) begin
      ntf_valid  <= 1'b0;
      ntf_inband <= 1'b0;
      ntf_port   <= 16'h0000;
      ntf_lines  <= 2'b00;
    end else begin
      ntf_valid <= ntf_fire;
      if (ntf_fire) begin
        ntf_inband <= inline_command_enable; // RULE12
        ntf_port   <= ntf_port_d;
        ntf_lines  <= ntf_lines_d;
      end
    end
  end

  // ==========================================================================
  // Escape collapsing of network data toward the serial side
  // In inline mode an escape byte is held back until the next byte shows
  // whether it was doubled data or the start of an embedded command.
  // A pending escape survives idle cycles between bytes and is dropped
  // only when inline mode is switched off.
  logic esc_pend_q;

  wire rx_is_esc  = net_rx_byte == modem_line_pkg::ESC_BYTE;
  wire rx_escaped = inline_command_enable && net_rx_valid;

  always_ff @(posedge ref_clk) begin
    if (!rst_b) begin
      esc_pend_q       <= 1'b0;
      ser_out_valid    <= 1'b0;
      ser_out_byte     <= 8'h00;
      inband_cmd_start <= 1'b0;
    end else begin
      ser_out_valid    <= 1'b0;
      inband_cmd_start <= 1'b0;
      if (!rx_escaped) begin
        esc_pend_q <= esc_pend_q & inline_command_enable;
        if (net_rx_valid) begin
          ser_out_valid <= 1'b1;
          ser_out_byte  <= net_rx_byte;
        end
      end else if (esc_pend_q) begin
        esc_pend_q <= 1'b0;
        if (rx_is_esc) begin
          ser_out_valid <= 1'b1; // RULE19
          ser_out_byte  <= modem_line_pkg::ESC_BYTE;
        end else begin
          inband_cmd_start <= 1'b1;
        end
      end else if (rx_is_esc) begin
        esc_pend_q <= 1'b1; // RULE19
      end else begin
        ser_out_valid <= 1'b1;
        ser_out_byte  <= net_rx_byte;
      end
    end
  end

  assign avs_waitrequest = wait_q;
  assign avs_readdata    = rdata_q;

endmodule : modem_line_remote_control

`default_nettype wire

// ===== test/modem_line_asserts.sv
// Assertion checker for the modem line remote control block.
// Sees only top-level ports; bound to every instance of the block.
`timescale 1ns/1ns
`default_nettype none

module modem_line_asserts #(
  parameter int unsigned DEBOUNCE_CYC = modem_line_pkg::DEBOUNCE_CYC
) (
  // Clock, reset and register bus
  input wire logic        ref_clk,
  input wire logic        rst_b,
  input wire logic [3:0]  avs_address,
  input wire logic        avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic        avs_waitrequest,
  // Commands
  input wire logic        cmd_valid,
  input wire logic [2:0]  cmd_code,
  input wire logic        cmd_arg,
  input wire logic        rsp_valid,
  input wire logic [7:0]  rsp_code,
  // Lines and notifications
  input wire logic        conn_up,
  input wire logic        cts_in,
  input wire logic        dsr_in,
  input wire logic        rx_almost_full,
  input wire logic        rts_out,
  input wire logic        dtr_out,
  input wire logic        ntf_valid,
  input wire logic [1:0]  ntf_lines
);
  // ==========================================================================
  // Helpers
  // Mirrors of the flow-control and line-ready-mode bits, and cycles since a raw line last moved.
  logic        fc_q;
  logic        lrm_q;
  logic        bus_ctrl;
  logic [1:0]  raw_q;
  int unsigned stab_q;
  assign bus_ctrl = avs_write && !avs_waitrequest && avs_address == 4'h0;
  always_ff @(posedge ref_clk) begin
    raw_q  <= {dsr_in, cts_in};
    stab_q <= ({dsr_in, cts_in} != raw_q) ? 0 : stab_q + 1;
    if (!rst_b) begin
      fc_q  <= 1'b0;
      lrm_q <= 1'b0;
    end else begin
      if (cmd_valid && cmd_code == 3'h3) fc_q <= cmd_arg;
      else if (bus_ctrl) fc_q <= avs_writedata[0];
      if (bus_ctrl) lrm_q <= avs_writedata[1];
    end
  end

  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rst_b);

  sequence s_cmd(c);
    cmd_valid && cmd_code == c;
  endsequence
  property p_rsp_once;
    cmd_valid |=> rsp_valid ##1 (!rsp_valid || $past(cmd_valid));
  endproperty
  property p_rsp_ok;
    (s_cmd(3'h1) or s_cmd(3'h2)) |=> rsp_code == 8'h41;
  endproperty
  property p_rts_obey;
    s_cmd(3'h1) ##0 !fc_q |=> ##1 rts_out == $past(cmd_arg, 2);
  endproperty
  property p_rts_own;
    fc_q && $past(fc_q) |-> rts_out == !$past(rx_almost_full);
  endproperty
  property p_dtr_obey;
    s_cmd(3'h2) ##0 !lrm_q |=> ##1 dtr_out == $past(cmd_arg, 2);
  endproperty
  property p_dtr_conn;
    lrm_q && $past(lrm_q) |-> dtr_out == $past(conn_up);
  endproperty
  property p_ntf_conn;
    ntf_valid |-> $past(conn_up);
  endproperty
  property p_ntf_stable;
    ntf_valid |-> stab_q >= DEBOUNCE_CYC - 1;
  endproperty
  property p_ntf_lines;
    ntf_valid |-> (ntf_lines & ~{dsr_in, cts_in}) == 2'b00;
  endproperty

  a_rsp_once:
    assert property (p_rsp_once) else $error("reply pulse wrong");
  a_rsp_ok:
    assert property (p_rsp_ok) else $error("line command not answered OK");
  a_rts_obey:
    assert property (p_rts_obey) else $error("RTS command not applied");
  a_rts_own:
    assert property (p_rts_own) else $error("RTS not throttling receive");
  a_dtr_obey:
    assert property (p_dtr_obey) else $error("DTR command not applied");
  a_dtr_conn:
    assert property (p_dtr_conn) else $error("DTR not following connection");
  a_ntf_conn:
    assert property (p_ntf_conn) else $error("notification without connection");
  a_ntf_stable:
    assert property (p_ntf_stable) else $error("notification before line settled");
  a_ntf_lines:
    assert property (p_ntf_lines) else $error("notified level not on the line");
endmodule : modem_line_asserts

bind modem_line_remote_control modem_line_asserts #(.DEBOUNCE_CYC(DEBOUNCE_CYC)) u_chk (
  .ref_clk, .rst_b, .avs_address, .avs_write, .avs_writedata, .avs_waitrequest, .cmd_valid,
  .cmd_code, .cmd_arg, .rsp_valid, .rsp_code, .conn_up, .cts_in, .dsr_in, .rx_almost_full,
  .rts_out, .dtr_out, .ntf_valid, .ntf_lines);

`default_nettype wire

// ===== test/virtual_port_host.sv
// Model of the remote virtual port host: sends commands and data bytes.
// Assumes one reply pulse per command; drives only after rising edges.
`timescale 1ns/1ns
`default_nettype none

module virtual_port_host #(
  parameter logic [15:0] SRC_PORT = 16'h1F40
) (
  // Clock
  input  wire logic        ref_clk,
  // Commands and replies
  output logic             cmd_valid,
  output logic [2:0]       cmd_code,
  output logic             cmd_arg,
  output logic [1:0]       cmd_mask,
  output logic [15:0]      cmd_src_port,
  input  wire logic        rsp_valid,
  input  wire logic [7:0]  rsp_code,
  // Data toward the device
  output logic             net_rx_valid,
  output logic [7:0]       net_rx_byte
);
  logic cmds_off;
  initial begin
    cmd_valid = 1'b0;
    cmd_code = 3'h0;
    cmd_arg = 1'b0;
    cmd_mask = 2'b00;
    cmd_src_port = SRC_PORT;
    net_rx_valid = 1'b0;
    net_rx_byte = 8'h00;
    cmds_off = 1'b0;
  end

  // A silent command goes out four times at most; a refusal stops commands.
  task automatic send(input logic [2:0] code, input logic arg, input logic [1:0] mask,
                      output logic ok);
    logic got;
    ok = 1'b0;
    for (int t = 0; t < 4 && !ok && !cmds_off; t++) begin
      @(posedge ref_clk);
      cmd_valid <= 1'b1;
      cmd_code <= code;
      cmd_arg <= arg;
      cmd_mask <= mask;
      @(posedge ref_clk);
      cmd_valid <= 1'b0;
      cmd_code <= ~code;
      got = 1'b0;
      for (int w = 0; w < 8 && !got; w++) begin
        @(posedge ref_clk);
        got = rsp_valid;
      end
      ok = got && rsp_code === 8'h41;
      if (got && !ok) cmds_off = 1'b1;
    end
    if (!ok) cmds_off = 1'b1;
  endtask : send

  task automatic reopen;
    cmds_off = 1'b0;
  endtask : reopen

  task automatic set_flow(input logic fc);
    logic ok;
    send(3'h3, fc, 2'b00, ok);
    send(3'h4, 1'b0, fc ? 2'b10 : 2'b11, ok);
  endtask : set_flow

  task automatic put(input logic [7:0] b, input logic dbl);
    @(posedge ref_clk);
    net_rx_valid <= 1'b1;
    net_rx_byte <= b;
    if (dbl && b == 8'hFF) @(posedge ref_clk);
    @(posedge ref_clk);
    net_rx_valid <= 1'b0;
    net_rx_byte <= ~b;
  endtask : put
endmodule : virtual_port_host

`default_nettype wire

// ===== test/testbench.sv
// Self-checking bench for the modem line remote control block.
// Assumes the host model and the bound checker; short debounce count.
`timescale 1ns/1ns
`default_nettype none

module testbench;
  localparam int unsigned DEB = 20;
  localparam logic [15:0] SRC = 16'h1F40;
  logic ref_clk, rst_b, avs_read, avs_write, avs_waitrequest, cmd_valid, cmd_arg, rsp_valid;
  logic net_rx_valid, ser_out_valid, conn_up, ntf_valid, ntf_inband, cts_in, dsr_in;
  logic rx_almost_full, rts_out, dtr_out, ser_tx_allow, ok, ni, ics;
  logic [3:0] avs_address;
  logic [31:0] avs_writedata, avs_readdata, q;
  logic [2:0] cmd_code;
  logic [1:0] cmd_mask, ntf_lines, nl;
  logic [15:0] cmd_src_port, ntf_port, np;
  logic [7:0] rsp_code, net_rx_byte, ser_out_byte, ob;
  int failures, comparisons, hits, outs, starts;

  modem_line_remote_control #(.DEBOUNCE_CYC(DEB)) u_dut (
    .ref_clk, .rst_b, .avs_address, .avs_read, .avs_write, .avs_writedata, .avs_readdata,
    .avs_waitrequest, .cmd_valid, .cmd_code, .cmd_arg, .cmd_mask, .cmd_src_port, .rsp_valid,
    .rsp_code, .net_rx_valid, .net_rx_byte, .ser_out_valid, .ser_out_byte,
    .inband_cmd_start(ics), .conn_up, .ntf_valid, .ntf_inband, .ntf_port, .ntf_lines, .cts_in,
    .dsr_in, .rx_almost_full, .rts_out, .dtr_out, .ser_tx_allow);
  virtual_port_host #(.SRC_PORT(SRC)) u_host (
    .ref_clk, .cmd_valid, .cmd_code, .cmd_arg, .cmd_mask, .cmd_src_port, .rsp_valid,
    .rsp_code, .net_rx_valid, .net_rx_byte);

  initial begin
    ref_clk = 1'b0;
    forever #20 ref_clk = ~ref_clk;
  end

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp) begin
      failures++;
      $display("FAIL t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk

  task automatic tally_and_finish;
    $display("comparisons=%0d failures=%0d", comparisons, failures);
    if (failures == 0 && comparisons > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask : tally_and_finish

  task automatic bus(input logic wr, input logic [3:0] a, input logic [31:0] d);
    int n;
    @(posedge ref_clk);
    avs_address <= a;
    avs_writedata <= d;
    avs_write <= wr;
    avs_read <= !wr;
    n = 0;
    do begin
      @(posedge ref_clk);
      n++;
    end while (avs_waitrequest !== 1'b0 && n < 20);
    q = avs_readdata;
    avs_write <= 1'b0;
    avs_read <= 1'b0;
    if (n >= 20) begin
      failures++;
      tally_and_finish;
    end
  endtask : bus

  // Counts notification and serial output pulses over n cycles.
  task automatic watch(input int n);
    hits = 0;
    outs = 0;
    starts = 0;
    repeat (n) begin
      @(negedge ref_clk);
      if (ntf_valid === 1'b1) begin
        hits++;
        {nl, ni, np} = {ntf_lines, ntf_inband, ntf_port};
      end
      if (ser_out_valid === 1'b1) begin
        outs++;
        ob = ser_out_byte;
      end
      if (ics === 1'b1) starts++;
    end
  endtask : watch

  task automatic t_regs;
    bus(1'b1, 4'h0, 32'h0000_0035);
    bus(1'b0, 4'h0, 32'h0);
    chk(q, 32'h0000_0035);
    bus(1'b1, 4'h6, 32'hFFFF_FFFF);
    bus(1'b0, 4'h6, 32'h0);
    chk(q, 32'h0);
    $display("t_regs done");
  endtask : t_regs

  task automatic t_rts;
    u_host.set_flow(1'b0);
    u_host.send(3'h1, 1'b1, 2'b00, ok);
    @(negedge ref_clk);
    chk({ok, rts_out}, 2'b11);
    u_host.set_flow(1'b1);
    bus(1'b0, 4'h0, 32'h0);
    chk(q, 32'h0000_0025);
    u_host.send(3'h1, 1'b0, 2'b00, ok);
    @(negedge ref_clk);
    chk({ok, rts_out}, 2'b11);
    @(posedge ref_clk);
    rx_almost_full <= 1'b1;
    repeat (2) @(negedge ref_clk);
    chk(rts_out, 1'b0);
    bus(1'b1, 4'h8, 32'h0);
    bus(1'b0, 4'h8, 32'h0);
    chk(q, {16'h0, SRC});
    $display("t_rts done");
  endtask : t_rts

  task automatic t_dtr;
    bus(1'b1, 4'h0, 32'h0);
    u_host.send(3'h2, 1'b1, 2'b00, ok);
    @(negedge ref_clk);
    chk({ok, dtr_out}, 2'b11);
    bus(1'b1, 4'h0, 32'h2);
    u_host.send(3'h2, 1'b1, 2'b00, ok);
    @(negedge ref_clk);
    chk({ok, dtr_out}, 2'b10);
    @(posedge ref_clk);
    conn_up <= 1'b1;
    repeat (2) @(negedge ref_clk);
    chk(dtr_out, 1'b1);
    u_host.send(3'h7, 1'b0, 2'b00, ok);
    chk({ok, rsp_code}, 9'h052);
    u_host.send(3'h1, 1'b1, 2'b00, ok);
    chk(ok, 1'b0);
    u_host.reopen();
    $display("t_dtr done");
  endtask : t_dtr

  task automatic t_ntf;
    bus(1'b1, 4'h0, 32'h31);
    @(posedge ref_clk);
    cts_in <= 1'b1;
    repeat (DEB - 5) @(posedge ref_clk);
    cts_in <= 1'b0;
    watch(DEB + 5);
    chk(hits, 0);
    @(posedge ref_clk);
    cts_in <= 1'b1;
    watch(DEB + 5);
    chk({hits[1:0], nl, ni, np}, {2'd1, 2'b01, 1'b0, SRC});
    chk(ser_tx_allow, 1'b1);
    @(posedge ref_clk);
    dsr_in <= 1'b1;
    watch(DEB + 5);
    chk({hits[1:0], nl}, 4'b0111);
    bus(1'b1, 4'h0, 32'h20);
    @(posedge ref_clk);
    cts_in <= 1'b0;
    watch(DEB + 5);
    chk(hits, 0);
    @(posedge ref_clk);
    conn_up <= 1'b0;
    dsr_in <= 1'b0;
    watch(DEB + 5);
    chk(hits, 0);
    bus(1'b1, 4'h0, 32'h24);
    @(posedge ref_clk);
    conn_up <= 1'b1;
    dsr_in <= 1'b1;
    watch(DEB + 5);
    chk({hits[1:0], nl, ni}, 5'b01101);
    u_host.send(3'h4, 1'b0, 2'b10, ok);
    chk(ok, 1'b1);
    $display("t_ntf done");
  endtask : t_ntf

  task automatic t_data;
    u_host.put(8'hFF, 1'b1);
    watch(4);
    chk({outs[1:0], ob}, 10'h1FF);
    u_host.put(8'h5A, 1'b1);
    watch(4);
    chk({outs[1:0], ob}, 10'h15A);
    u_host.put(8'hFF, 1'b0);
    u_host.put(8'h3C, 1'b1);
    watch(4);
    chk({starts[1:0], outs[1:0]}, 4'h4);
    bus(1'b1, 4'h0, 32'h20);
    u_host.put(8'hFF, 1'b0);
    watch(4);
    chk({outs[1:0], ob}, 10'h1FF);
    $display("t_data done");
  endtask : t_data

  task automatic t_noport;
    @(posedge ref_clk);
    rst_b <= 1'b0;
    dsr_in <= 1'b0;
    repeat (3) @(posedge ref_clk);
    rst_b <= 1'b1;
    bus(1'b1, 4'h0, 32'h30);
    @(posedge ref_clk);
    cts_in <= 1'b1;
    watch(DEB + 5);
    chk(hits, 0);
    bus(1'b1, 4'hC, 32'h1234);
    bus(1'b1, 4'h0, 32'h38);
    @(posedge ref_clk);
    cts_in <= 1'b0;
    watch(DEB + 5);
    chk({hits[1:0], nl, ni, np}, {2'd1, 2'b00, 1'b0, 16'h1234});
    $display("t_noport done");
  endtask : t_noport

  initial begin
    {rst_b, avs_read, avs_write, conn_up, cts_in, dsr_in, rx_almost_full} = 7'h00;
    avs_address = 4'h0;
    avs_writedata = 32'h0;
    failures = 0;
    comparisons = 0;
    repeat (10) @(posedge ref_clk);
    rst_b <= 1'b1;
    t_regs();
    t_rts();
    t_dtr();
    t_ntf();
    t_data();
    t_noport();
    tally_and_finish();
  end
endmodule : testbench

`default_nettype wire
